// >>> srq_status_pkg.sv
// shared constants for the service-request and status-byte logic
package srq_status_pkg;
    // status byte bit positions; mask bits sit at the same positions
    localparam int unsigned DWELL_BIT = 2;
    localparam int unsigned BUFFER_BIT = 3;
    localparam int unsigned READY_BIT = 4;
    localparam int unsigned ERROR_BIT = 5;
    localparam int unsigned REQUEST_BIT = 6;
    // weights of the decimal mask command value
    localparam int unsigned CMD_ERROR_POS = 0;
    localparam int unsigned CMD_READY_POS = 1;
    localparam int unsigned CMD_BUFFER_POS = 2;
    localparam int unsigned CMD_DWELL_POS = 3;
    // values after reset
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [3:0] CMD_VALUE_RESET = 4'h0;
    // mask field that may ever be set: bits 2..5, never bit 6
    localparam logic [7:0] MASK_LEGAL = 8'h3C;
endpackage : srq_status_pkg

// >>> condition_cell.sv
// one instrument condition bit, either live or held until polled
`timescale 1ns/10ps
module condition_cell #(
    parameter bit STICKY = 1'b0
) (
    input wire logic mclk, // system clock
    input wire logic sys_rst, // async reset, active high
    input wire logic cond_in, // raw condition, same clock domain
    input wire logic poll_clr, // serial poll read strobe
    output logic cond_ff // condition as the status byte sees it
);
    // =========================================================
    // condition hold
    // sticky bits let the set win over a poll in the same cycle
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cond_ff <= 1'b0;
        end
        else if (STICKY)
        begin
            cond_ff <= cond_in | (cond_ff & ~poll_clr);
        end
        else
        begin
            cond_ff <= cond_in;
        end
    end
endmodule : condition_cell

// >>> service_request_status_logic.sv
// service-request mask, status byte latch and request line
`timescale 1ns/10ps
// How it works
// - mask command value 0..15 builds enable mask
// - value zero clears every mask bit
// - mask eight bits, bit 6 never held
// - bad command, option or local programming: error
// - last program location while running: end buffer
// - dwell expiry while running: end dwell
// - enabled condition raises request and bit 6
// - status bit 5 reports the error
// - serial poll read releases the request line
// - status byte frozen while request pending
// - poll read clears bit 6 and the held error and dwell bits
// - without request, bits 2..5 follow conditions
// - error bit held until the poll read
// - status byte readable by poll any time
module service_request_status_logic
    import srq_status_pkg::*;
(
    input wire logic mclk, // system clock, 100 MHz
    input wire logic sys_rst, // async reset, active high
    input wire logic mask_cmd_valid, // pulse: mask command parsed
    input wire logic [3:0] mask_cmd_value, // decimal value of the mask command
    input wire logic exec_char, // pulse: execute character received
    input wire logic illegal_command_error, // pulse: illegal command seen
    input wire logic illegal_option_error, // pulse: illegal option seen
    input wire logic not_remote_error, // pulse: programmed while not remote
    input wire logic ready_level, // level: instrument ready
    input wire logic program_running, // level: stored program executing
    input wire logic last_location, // level: sequencer at last location
    input wire logic dwell_expired, // pulse: step dwell period ended
    input wire logic serial_poll_rd, // pulse: controller read status byte
    output logic srq_ff, // service request line, active high
    output logic [7:0] status_byte_ff, // status byte presented to poll
    output logic [7:0] request_enable_mask_ff // active request mask
);
    // =========================================================
    // declarations
    logic [3:0] pend_value_ff;
    logic pend_valid_ff;
    logic [7:0] nxt_mask;
    logic [7:0] cond_vec;
    logic [7:0] prev_hit_ff;
    logic [7:0] hit;
    logic req_rise;
    logic err_event;
    logic buf_event;
    logic dwell_event;
    logic cond_err;
    logic cond_ready;
    logic cond_buf;
    logic cond_dwell;

    // =========================================================
    // condition sources
    // error sources merged
    assign err_event = illegal_command_error | illegal_option_error | not_remote_error;
    // end of buffer only while running
    assign buf_event = program_running & last_location;
    assign dwell_event = program_running & dwell_expired;

    condition_cell #(.STICKY(1'b1)) u_err (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .cond_in(err_event),
        .poll_clr(serial_poll_rd),
        .cond_ff(cond_err)
    );
    // ready and buffer are levels, so they stay live
    condition_cell #(.STICKY(1'b0)) u_ready (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .cond_in(ready_level),
        .poll_clr(serial_poll_rd),
        .cond_ff(cond_ready)
    );
    condition_cell #(.STICKY(1'b0)) u_buf (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .cond_in(buf_event),
        .poll_clr(serial_poll_rd),
        .cond_ff(cond_buf)
    );
    // dwell end is a pulse; held so the poll can still see it
    condition_cell #(.STICKY(1'b1)) u_dwell (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .cond_in(dwell_event),
        .poll_clr(serial_poll_rd),
        .cond_ff(cond_dwell)
    );

    // condition vector in status byte layout
    always_comb
    begin
        cond_vec = 8'h00;
        cond_vec[ERROR_BIT] = cond_err;
        cond_vec[READY_BIT] = cond_ready;
        cond_vec[BUFFER_BIT] = cond_buf;
        cond_vec[DWELL_BIT] = cond_dwell;
    end

    // =========================================================
    // mask command
    // decimal weights mapped onto status positions
    always_comb
    begin
        nxt_mask = 8'h00;
        nxt_mask[ERROR_BIT] = pend_value_ff[CMD_ERROR_POS];
        nxt_mask[READY_BIT] = pend_value_ff[CMD_READY_POS];
        nxt_mask[BUFFER_BIT] = pend_value_ff[CMD_BUFFER_POS];
        nxt_mask[DWELL_BIT] = pend_value_ff[CMD_DWELL_POS];
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pend_value_ff <= CMD_VALUE_RESET;
            pend_valid_ff <= 1'b0;
        end
        else if (mask_cmd_valid)
        begin
            pend_value_ff <= mask_cmd_value;
            pend_valid_ff <= 1'b1;
        end
        else if (exec_char)
        begin
            pend_valid_ff <= 1'b0;
        end
    end

    // zero value yields an all-clear mask
    // legal field keeps bit 6 out
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            request_enable_mask_ff <= MASK_RESET;
        end
        else if (exec_char && pend_valid_ff)
        begin
            request_enable_mask_ff <= nxt_mask & MASK_LEGAL;
        end
    end

    // =========================================================
    // request detection
    // rising edge of any enabled condition
    assign hit = cond_vec & request_enable_mask_ff;
    assign req_rise = |(hit & ~prev_hit_ff);

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prev_hit_ff <= 8'h00;
        end
        else
        begin
            prev_hit_ff <= hit;
        end
    end

    // request line; poll releases it, new request wins
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            srq_ff <= 1'b0;
        end
        else if (req_rise && (!srq_ff || serial_poll_rd))
        begin
            srq_ff <= 1'b1;
        end
        else if (serial_poll_rd)
        begin
            srq_ff <= 1'b0;
        end
    end

    // =========================================================
    // status byte
    // frozen while pending; live otherwise
    // poll drops latched value back to live conditions
    // error shows at bit 5; readable at any time
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            status_byte_ff <= STATUS_RESET;
        end
        else if (req_rise && (!srq_ff || serial_poll_rd))
        begin
            status_byte_ff <= cond_vec | (8'h01 << REQUEST_BIT);
        end
        else if (!srq_ff || serial_poll_rd)
        begin
            status_byte_ff <= cond_vec;
        end
    end

    // =========================================================
    // assertions
    a_mask_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        exec_char && pend_valid_ff && pend_value_ff == 4'h0 |=> request_enable_mask_ff == 8'h00)
        else $error("zero mask value left bits set");
    a_mask_bit6: assert property (@(posedge mclk) disable iff (sys_rst)
        request_enable_mask_ff[REQUEST_BIT] == 1'b0)
        else $error("mask holds bit 6");
    a_mask_weights: assert property (@(posedge mclk) disable iff (sys_rst)
        exec_char && pend_valid_ff && pend_value_ff == 4'h1 |=> request_enable_mask_ff == 8'h20)
        else $error("mask value one did not enable error only");
    a_mask_pending: assert property (@(posedge mclk) disable iff (sys_rst)
        !exec_char |=> $stable(request_enable_mask_ff))
        else $error("mask changed without execute");
    a_err_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
        err_event ##1 !serial_poll_rd |=> cond_err)
        else $error("error bit lost before poll");
    a_buf_set: assert property (@(posedge mclk) disable iff (sys_rst)
        program_running && last_location |=> cond_buf)
        else $error("end of buffer not raised");
    a_dwell_set: assert property (@(posedge mclk) disable iff (sys_rst)
        program_running && dwell_expired |=> cond_dwell)
        else $error("end of dwell not raised");
    a_srq_raise: assert property (@(posedge mclk) disable iff (sys_rst)
        err_event && request_enable_mask_ff[ERROR_BIT] && !cond_err && !srq_ff && !exec_char && !req_rise
        |=> ##1 srq_ff && status_byte_ff[REQUEST_BIT] && status_byte_ff[ERROR_BIT])
        else $error("enabled error did not raise request");
    a_poll_release: assert property (@(posedge mclk) disable iff (sys_rst)
        serial_poll_rd && !req_rise |=> !srq_ff && !status_byte_ff[REQUEST_BIT])
        else $error("poll did not release request");
    a_poll_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        serial_poll_rd && !err_event |=> !cond_err)
        else $error("poll did not clear error bit");
    a_status_freeze: assert property (@(posedge mclk) disable iff (sys_rst)
        srq_ff && !serial_poll_rd |=> $stable(status_byte_ff))
        else $error("status byte moved while pending");
    a_status_live: assert property (@(posedge mclk) disable iff (sys_rst)
        !srq_ff ##1 !srq_ff |-> status_byte_ff[5:2] == $past(cond_vec[5:2]))
        else $error("status bits not following conditions");

    c_poll_masked_off: cover property (@(posedge mclk) disable iff (sys_rst)
        request_enable_mask_ff == 8'h00 && serial_poll_rd);
    c_request_poll: cover property (@(posedge mclk) disable iff (sys_rst)
        srq_ff ##[1:20] serial_poll_rd);
    c_set_vs_poll: cover property (@(posedge mclk) disable iff (sys_rst)
        srq_ff && serial_poll_rd && req_rise);
    c_dwell_request: cover property (@(posedge mclk) disable iff (sys_rst)
        dwell_event && request_enable_mask_ff[DWELL_BIT] ##2 srq_ff);
endmodule : service_request_status_logic

// >>> srq_poll_controller.sv
// bus controller model that serial polls the device
`timescale 1ns/10ps
module srq_poll_controller (
    input wire logic mclk, // system clock
    input wire logic sys_rst, // async reset, active high
    input wire logic srq_ff, // request line from the device
    input wire logic [7:0] status_byte_ff, // byte offered on a poll
    input wire logic poll_now, // bench asks for a poll
    input wire logic auto_poll, // answer requests when set
    output logic serial_poll_rd, // one-cycle poll strobe
    output logic [7:0] polled_byte // last byte read
);
    logic want;
    // ========
    // poll decision, held off while a strobe is out so polls never merge
    // poll on request or at any time
    always @(posedge mclk or posedge sys_rst)
        if (sys_rst)
            want <= 1'b0;
        else
            want <= !serial_poll_rd && (poll_now || (auto_poll && srq_ff));
    // strobe changes off the sampling edge
    always @(negedge mclk or posedge sys_rst)
        if (sys_rst)
            serial_poll_rd <= 1'b0;
        else
            serial_poll_rd <= want && !serial_poll_rd;
    // byte taken at the edge that takes the poll
    always @(posedge mclk or posedge sys_rst)
        if (sys_rst)
            polled_byte <= 8'h00;
        else if (serial_poll_rd)
            polled_byte <= status_byte_ff;
endmodule : srq_poll_controller

// >>> service_request_status_logic_tb_top.sv
// testbench for the service-request and status-byte logic
`timescale 1ns/10ps
module service_request_status_logic_tb_top;
    import srq_status_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic mask_cmd_valid = 1'b0;
    logic [3:0] mask_cmd_value = 4'h0;
    logic exec_char = 1'b0;
    logic [2:0] err_in = 3'h0; // command, option, not remote
    logic ready_level = 1'b0;
    logic program_running = 1'b0;
    logic last_location = 1'b0;
    logic dwell_expired = 1'b0;
    logic poll_now = 1'b0;
    logic auto_poll = 1'b0;
    logic serial_poll_rd;
    logic srq_ff;
    logic [7:0] status_byte_ff;
    logic [7:0] request_enable_mask_ff;
    logic [7:0] polled_byte;
    logic [7:0] exp_mask = 8'h00;
    int errors = 0;
    int tests_run = 0;
    // ========
    service_request_status_logic service_request_status_logic_inst (.mclk(mclk), .sys_rst(sys_rst),
        .mask_cmd_valid(mask_cmd_valid), .mask_cmd_value(mask_cmd_value), .exec_char(exec_char),
        .illegal_command_error(err_in[0]), .illegal_option_error(err_in[1]),
        .not_remote_error(err_in[2]), .ready_level(ready_level), .program_running(program_running),
        .last_location(last_location), .dwell_expired(dwell_expired), .serial_poll_rd(serial_poll_rd),
        .srq_ff(srq_ff), .status_byte_ff(status_byte_ff), .request_enable_mask_ff(request_enable_mask_ff));
    srq_poll_controller srq_poll_controller_inst (.mclk(mclk), .sys_rst(sys_rst), .srq_ff(srq_ff),
        .status_byte_ff(status_byte_ff), .poll_now(poll_now), .auto_poll(auto_poll),
        .serial_poll_rd(serial_poll_rd), .polled_byte(polled_byte));
    // 100 MHz clock
    initial
    begin
        forever #5 mclk = ~mclk;
    end
    // ========
    task step(input int n);
        repeat (n) @(negedge mclk);
    endtask : step
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // value first, execute three cycles later so the hold is visible
    task set_mask(input logic [3:0] v);
        mask_cmd_valid = 1'b1;
        mask_cmd_value = v;
        step(1);
        mask_cmd_valid = 1'b0;
        step(2);
        chk("mask before exec", exp_mask, request_enable_mask_ff);
        exec_char = 1'b1;
        step(1);
        exec_char = 1'b0;
        step(1);
        exp_mask = 8'h00;
        exp_mask[ERROR_BIT] = v[CMD_ERROR_POS];
        exp_mask[READY_BIT] = v[CMD_READY_POS];
        exp_mask[BUFFER_BIT] = v[CMD_BUFFER_POS];
        exp_mask[DWELL_BIT] = v[CMD_DWELL_POS];
        chk("mask", exp_mask, request_enable_mask_ff);
    endtask : set_mask
    task poll();
        poll_now = 1'b1;
        step(1);
        poll_now = 1'b0;
        step(3);
    endtask : poll
    // raise one condition under its mask, freeze, poll, clear
    task fire(input logic [3:0] v, input int kind, input logic [7:0] exp);
        set_mask(v);
        program_running = 1'b1;
        if (kind == 0)
            dwell_expired = 1'b1;
        else if (kind == 1)
            last_location = 1'b1;
        else
            err_in[kind-2] = 1'b1;
        step(1);
        dwell_expired = 1'b0;
        err_in = 3'h0;
        step(2);
        chk("request", 8'h01, {7'h00, srq_ff});
        chk("frozen byte", exp, status_byte_ff);
        ready_level = 1'b1;
        step(3);
        chk("still frozen", exp, status_byte_ff);
        auto_poll = 1'b1;
        step(4);
        auto_poll = 1'b0;
        ready_level = 1'b0;
        last_location = 1'b0;
        program_running = 1'b0;
        chk("polled", exp, polled_byte);
        chk("released", 8'h00, {7'h00, srq_ff});
        step(3);
        chk("cleared", 8'h00, status_byte_ff);
    endtask : fire
    task test_done();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    // ========
    // main sequence
    initial
    begin
        step(5);
        sys_rst = 1'b0;
        step(1);
        for (int i = 15; i >= 0; i--)
            set_mask(i[3:0]);
        $display("test masks done");
        ready_level = 1'b1;
        last_location = 1'b1;
        step(3);
        chk("live ready", 8'h10, status_byte_ff);
        program_running = 1'b1;
        step(3);
        chk("live buffer", 8'h18, status_byte_ff);
        ready_level = 1'b0;
        last_location = 1'b0;
        program_running = 1'b0;
        err_in[1] = 1'b1;
        step(1);
        err_in = 3'h0;
        step(4);
        chk("error held", 8'h20, status_byte_ff);
        chk("no request", 8'h00, {7'h00, srq_ff});
        poll();
        chk("polled", 8'h20, polled_byte);
        chk("error cleared", 8'h00, status_byte_ff);
        $display("test live status done");
        fire(4'h8, 0, 8'h44);
        fire(4'h4, 1, 8'h48);
        for (int k = 2; k < 5; k++)
            fire(4'h1, k, 8'h60);
        $display("test requests done");
        test_done();
    end
    // watchdog far beyond the roughly 190 cycles needed
    initial
    begin
        #50000;
        errors++;
        test_done();
    end
endmodule : service_request_status_logic_tb_top
